// ### common/usbsc_pkg.sv
// Constants and types shared by the control/status front end and its controller.
// Assumes one 25 MHz clock and an active-low asynchronous reset in every module.
package usbsc_pkg;

    // ************************************************************
    // Device register indices
    // ************************************************************
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_CFG = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;
    localparam logic [1:0] REG_DONE = 2'h3;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_PPCLR = 6;
    localparam int CTRL_SE0 = 5;
    localparam int CTRL_LOCK = 4;
    localparam int CTRL_EN = 3;
    localparam int CTRL_RESUME = 2;
    localparam int CTRL_HOLD = 1;
    localparam int CFG_EYE = 7;
    localparam int CFG_PULLUP = 4;
    localparam int CFG_SPEED = 2;
    localparam int CFG_PPM_HI = 1;
    localparam int CFG_PPM_LO = 0;
    localparam int STAT_ENDP_LO = 3;
    localparam int STAT_DIR = 2;
    localparam int STAT_BANK = 1;
    localparam int DONE_FLAG = 0;

    // ************************************************************
    // Write masks and reset values
    // ************************************************************
    localparam logic [7:0] CTRL_WMASK = 8'h4E;
    localparam logic [7:0] CFG_WMASK = 8'h97;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ************************************************************
    // Transaction status queue
    // ************************************************************
    localparam int QDEPTH = 4;
    localparam logic [2:0] QFULL = 3'h4;

    typedef struct packed {
        logic [3:0] endp;
        logic dir;
        logic bank;
    } usbsc_xfer_type;

    // ************************************************************
    // Clock figures
    // ************************************************************
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam logic [7:0] FS_CLK_MHZ = 8'h30;
    localparam logic [7:0] LS_CLK_MHZ = 8'h06;

    // ************************************************************
    // Controller AHB map
    // ************************************************************
    localparam logic [31:0] AHB_CMD_OFS = 32'h0000_0000;
    localparam logic [31:0] AHB_RES_OFS = 32'h0000_0004;
    localparam int CMD_DATA_LO = 0;
    localparam int CMD_IDX_LO = 8;
    localparam int CMD_READ = 16;
    localparam int RES_BUSY = 8;
    localparam int RES_REFUSED = 9;
    localparam int RES_ENABLED = 10;

endpackage : usbsc_pkg

// ### common/usbsc_reg_if.sv
// Register port between the front end and its controller.
// Assumes both ends run on the same sys_clk; no clock travels here.
`timescale 1ns/1ns
interface usbsc_reg_if;
    logic regReq;
    logic regWe;
    logic [1:0] regIdx;
    logic [7:0] regWdata;
    logic regAck;
    logic [7:0] regRdata;

    modport dev (
        input regReq,
        input regWe,
        input regIdx,
        input regWdata,
        output regAck,
        output regRdata
    );

    modport ctl (
        output regReq,
        output regWe,
        output regIdx,
        output regWdata,
        input regAck,
        input regRdata
    );
endinterface : usbsc_reg_if

// ### design/usbsc_controller.sv
// Controller end: AHB-Lite slave that relays firmware orders to the front end.
// Assumes a single AHB master, word transfers only, and hready fed from hreadyout.
`timescale 1ns/1ns
module usbsc_controller (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Clock source report
    input wire logic [7:0] moduleClkMhz,
    // Register port
    usbsc_reg_if.ctl regs,
    // Status
    output logic cmdBusy,
    output logic cmdRefused
);

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_ISSUE = 2'b01,
        CS_WAIT = 2'b10
    } usbsc_cstate_type;

    typedef struct packed {
        usbsc_cstate_type state;
        logic apValid;
        logic apCmd;
        logic [31:0] rdata;
        logic refused;
        logic [7:0] lastData;
        logic isWrite;
        logic [1:0] idx;
        logic [7:0] data;
        logic shEnable;
        logic shPullup;
        logic shSpeed;
    } usbsc_ctl_state_type;

    usbsc_ctl_state_type s_q;
    usbsc_ctl_state_type s_d;

    logic cmdRead;
    logic [1:0] cmdIdx;
    logic [7:0] cmdData;
    logic deny;
    logic [7:0] needMhz;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        cmdRead = hwdata[usbsc_pkg::CMD_READ];
        cmdIdx = hwdata[usbsc_pkg::CMD_IDX_LO +: 2];
        cmdData = hwdata[usbsc_pkg::CMD_DATA_LO +: 8];
        if (cmdIdx == usbsc_pkg::REG_CFG) begin
            cmdData = cmdData & usbsc_pkg::CFG_WMASK;
        end
        needMhz = s_q.shSpeed ? usbsc_pkg::FS_CLK_MHZ : usbsc_pkg::LS_CLK_MHZ;
        deny = 1'b0;
        if (!cmdRead && cmdIdx == usbsc_pkg::REG_CTRL && cmdData[usbsc_pkg::CTRL_EN]
            && !s_q.shEnable && moduleClkMhz != needMhz) begin
            deny = 1'b1;
        end
        if (!cmdRead && cmdIdx == usbsc_pkg::REG_CFG && s_q.shEnable
            && (cmdData[usbsc_pkg::CFG_PULLUP] != s_q.shPullup
            || cmdData[usbsc_pkg::CFG_SPEED] != s_q.shSpeed)) begin
            deny = 1'b1;
        end

        s_d = s_q;
        if (hready) begin
            s_d.apValid = hsel & htrans[1];
            s_d.apCmd = hsel & htrans[1] & hwrite & (haddr == usbsc_pkg::AHB_CMD_OFS);
            if (hsel && htrans[1] && !hwrite) begin
                s_d.rdata = 32'h0000_0000;
                if (haddr == usbsc_pkg::AHB_RES_OFS) begin
                    s_d.rdata[7:0] = s_q.lastData;
                    s_d.rdata[usbsc_pkg::RES_BUSY] = (s_q.state != CS_IDLE);
                    s_d.rdata[usbsc_pkg::RES_REFUSED] = s_q.refused;
                    s_d.rdata[usbsc_pkg::RES_ENABLED] = s_q.shEnable;
                end
            end
        end

        unique case (s_q.state)
            CS_IDLE: begin
                if (s_q.apCmd) begin
                    s_d.refused = deny;
                    if (!deny) begin
                        s_d.state = CS_ISSUE;
                        s_d.isWrite = ~cmdRead;
                        s_d.idx = cmdIdx;
                        s_d.data = cmdData;
                    end
                end
            end
            CS_ISSUE: begin
                s_d.state = CS_WAIT;
                if (s_q.isWrite && s_q.idx == usbsc_pkg::REG_CTRL) begin
                    s_d.shEnable = s_q.data[usbsc_pkg::CTRL_EN];
                end
                if (s_q.isWrite && s_q.idx == usbsc_pkg::REG_CFG) begin
                    s_d.shPullup = s_q.data[usbsc_pkg::CFG_PULLUP];
                    s_d.shSpeed = s_q.data[usbsc_pkg::CFG_SPEED];
                end
            end
            CS_WAIT: begin
                if (regs.regAck) begin
                    s_d.lastData = regs.regRdata;
                    s_d.state = CS_IDLE;
                end
            end
            default: begin
                s_d.state = CS_IDLE;
            end
        endcase
        // A command arriving while one is in flight is dropped and flagged
        if (s_q.apCmd && s_q.state != CS_IDLE) begin
            s_d.refused = 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.state <= CS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign regs.regReq = (s_q.state == CS_ISSUE);
    assign regs.regWe = (s_q.state == CS_ISSUE) & s_q.isWrite;
    assign regs.regIdx = s_q.idx;
    assign regs.regWdata = s_q.data;
    assign cmdBusy = (s_q.state != CS_IDLE);
    assign cmdRefused = s_q.refused;

endmodule : usbsc_controller

// ### design/usbsc_device.sv
// Control, configuration and status front end of the serial interface engine.
// Assumes the engine supplies one-cycle event pulses and bus lines synchronous to sys_clk.
`timescale 1ns/1ns
module usbsc_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    usbsc_reg_if.dev regs,
    // Bus line levels
    input wire logic busDp,
    input wire logic busDm,
    // Engine events
    input wire logic setupSeen,
    input wire logic xferDone,
    input wire logic [3:0] xferEndp,
    input wire logic xferDir,
    input wire logic xferBank,
    // Engine and transceiver controls
    output logic moduleEnable,
    output logic resumeDrive,
    output logic engineClkRun,
    output logic packetLockout,
    output logic pingpongPointerClear,
    output logic [1:0] pingpongMode,
    output logic eyeTestEnable,
    output logic speedSelect,
    output logic pullupDp,
    output logic pullupDm,
    output logic pinChangeDetectEnable,
    output logic transactionDone,
    output logic statusQueueFull
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        usbsc_pkg::usbsc_xfer_type [usbsc_pkg::QDEPTH-1:0] queue;
        logic [1:0] rdPtr;
        logic [1:0] wrPtr;
        logic [2:0] count;
        logic ack;
        logic [7:0] rdata;
    } usbsc_dev_state_type;

    usbsc_dev_state_type s_q;
    usbsc_dev_state_type s_d;

    logic se0Live;
    logic wrAccess;
    logic push;
    logic pop;
    logic notEmpty;
    logic [7:0] readValue;
    usbsc_pkg::usbsc_xfer_type head;
    usbsc_pkg::usbsc_xfer_type incoming;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        se0Live = ~busDp & ~busDm;
        wrAccess = regs.regReq & regs.regWe;
        notEmpty = (s_q.count != 3'h0);
        incoming.endp = xferEndp;
        incoming.dir = xferDir;
        incoming.bank = xferBank;
        head = s_q.queue[s_q.rdPtr];
        // A full queue drops the newest entry; the engine sees statusQueueFull first
        push = xferDone & (s_q.count != usbsc_pkg::QFULL);
        pop = wrAccess & (regs.regIdx == usbsc_pkg::REG_DONE)
            & regs.regWdata[usbsc_pkg::DONE_FLAG] & notEmpty;

        readValue = 8'h00;
        unique case (regs.regIdx)
            usbsc_pkg::REG_CTRL: begin
                readValue = s_q.ctrl;
                readValue[usbsc_pkg::CTRL_SE0] = se0Live;
            end
            usbsc_pkg::REG_CFG: begin
                readValue = s_q.cfg;
            end
            usbsc_pkg::REG_STAT: begin
                if (notEmpty) begin
                    readValue[usbsc_pkg::STAT_ENDP_LO +: 4] = head.endp;
                    readValue[usbsc_pkg::STAT_DIR] = head.dir;
                    readValue[usbsc_pkg::STAT_BANK] = head.bank;
                end
            end
            usbsc_pkg::REG_DONE: begin
                readValue[usbsc_pkg::DONE_FLAG] = notEmpty;
            end
        endcase

        s_d = s_q;
        s_d.ack = regs.regReq;
        if (regs.regReq) begin
            s_d.rdata = readValue;
        end

        if (wrAccess && regs.regIdx == usbsc_pkg::REG_CTRL) begin
            // Enable, resume, hold and pointer clear are plain read/write
            s_d.ctrl = (s_q.ctrl & ~usbsc_pkg::CTRL_WMASK)
                | (regs.regWdata & usbsc_pkg::CTRL_WMASK);
            if (!regs.regWdata[usbsc_pkg::CTRL_LOCK]) begin
                s_d.ctrl[usbsc_pkg::CTRL_LOCK] = 1'b0;
            end
        end
        // Setting comes after clearing so a SETUP in the clear cycle is kept
        if (setupSeen) begin
            s_d.ctrl[usbsc_pkg::CTRL_LOCK] = 1'b1;
        end

        if (wrAccess && regs.regIdx == usbsc_pkg::REG_CFG) begin
            s_d.cfg = regs.regWdata & usbsc_pkg::CFG_WMASK;
        end

        // All three fields of an entry are written in one cycle
        if (push) begin
            s_d.queue[s_q.wrPtr] = incoming;
            s_d.wrPtr = s_q.wrPtr + 2'h1;
        end
        if (pop) begin
            s_d.rdPtr = s_q.rdPtr + 2'h1;
        end
        s_d.count = s_q.count + {2'h0, push} - {2'h0, pop};
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.ctrl <= usbsc_pkg::CTRL_RESET;
            s_q.cfg <= usbsc_pkg::CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign regs.regAck = s_q.ack;
    assign regs.regRdata = s_q.rdata;
    assign moduleEnable = s_q.ctrl[usbsc_pkg::CTRL_EN];
    assign resumeDrive = s_q.ctrl[usbsc_pkg::CTRL_RESUME];
    assign engineClkRun = ~s_q.ctrl[usbsc_pkg::CTRL_HOLD];
    assign packetLockout = s_q.ctrl[usbsc_pkg::CTRL_LOCK];
    // Held while the bit stays set, so the engine sees the clear for as long as asked
    assign pingpongPointerClear = s_q.ctrl[usbsc_pkg::CTRL_PPCLR];
    assign pingpongMode = s_q.cfg[usbsc_pkg::CFG_PPM_HI:usbsc_pkg::CFG_PPM_LO];
    assign eyeTestEnable = s_q.cfg[usbsc_pkg::CFG_EYE];
    assign speedSelect = s_q.cfg[usbsc_pkg::CFG_SPEED];
    assign pullupDp = s_q.cfg[usbsc_pkg::CFG_PULLUP] & s_q.cfg[usbsc_pkg::CFG_SPEED];
    assign pullupDm = s_q.cfg[usbsc_pkg::CFG_PULLUP] & ~s_q.cfg[usbsc_pkg::CFG_SPEED];
    assign pinChangeDetectEnable = ~s_q.ctrl[usbsc_pkg::CTRL_EN];
    assign transactionDone = (s_q.count != 3'h0);
    assign statusQueueFull = (s_q.count == usbsc_pkg::QFULL);

endmodule : usbsc_device

// ### tb/testbench.sv
// Self-checking bench: AHB master on the controller, engine events on the front end.
// Assumes the two design ends meet through usbsc_reg_if and share sys_clk.
`timescale 1ns/1ns
module testbench;
    // ************************************************************
    // Signals
    // ************************************************************
    logic sys_clk, rstn, hsel, hwrite, hresp, cmdBusy, cmdRefused;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, pingpongMode;
    logic [2:0] hsize;
    logic [7:0] moduleClkMhz;
    logic busDp, busDm, setupSeen, xferDone, xferDir, xferBank, hreadyout;
    logic [3:0] xferEndp;
    logic moduleEnable, resumeDrive, engineClkRun, packetLockout, pingpongPointerClear;
    logic eyeTestEnable, speedSelect, pullupDp, pullupDm, pinChangeDetectEnable;
    logic transactionDone, statusQueueFull;
    wire logic hready;
    int mismatches = 0;
    int samplesChecked = 0;
    logic [31:0] res;
    logic [7:0] rv;
    assign hready = hreadyout;

    usbsc_reg_if regLink();
    usbsc_controller u_usbsc_controller (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .moduleClkMhz(moduleClkMhz), .regs(regLink.ctl), .cmdBusy(cmdBusy),
        .cmdRefused(cmdRefused));
    usbsc_device u_usbsc_device (.sys_clk(sys_clk), .rstn(rstn), .regs(regLink.dev),
        .busDp(busDp), .busDm(busDm), .setupSeen(setupSeen), .xferDone(xferDone),
        .xferEndp(xferEndp), .xferDir(xferDir), .xferBank(xferBank),
        .moduleEnable(moduleEnable), .resumeDrive(resumeDrive), .engineClkRun(engineClkRun),
        .packetLockout(packetLockout), .pingpongPointerClear(pingpongPointerClear),
        .pingpongMode(pingpongMode), .eyeTestEnable(eyeTestEnable),
        .speedSelect(speedSelect), .pullupDp(pullupDp), .pullupDm(pullupDm),
        .pinChangeDetectEnable(pinChangeDetectEnable), .transactionDone(transactionDone),
        .statusQueueFull(statusQueueFull));
    usbsc_monitor u_usbsc_monitor (.sys_clk(sys_clk), .rstn(rstn),
        .regReq(regLink.regReq), .regWe(regLink.regWe), .regIdx(regLink.regIdx),
        .regWdata(regLink.regWdata), .regAck(regLink.regAck), .regRdata(regLink.regRdata));

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Polls the result word up to 20 times; a command still busy after that counts as a mismatch
    task automatic cmd(input logic rd, input logic [1:0] idx, input logic [7:0] d);
        ahb(1'b1, usbsc_pkg::AHB_CMD_OFS, {15'h0000, rd, 6'h00, idx, d}, res);
        res = 32'h0000_0100;
        for (int i = 0; i < 20 && res[8] !== 1'b0; i++) begin
            ahb(1'b0, usbsc_pkg::AHB_RES_OFS, 32'h0000_0000, res);
        end
        // A command that never leaves busy counts against the run
        if (res[8] !== 1'b0) begin
            mismatches++;
            $display("Error cmdBusy expected 0 seen %b", res[8]);
        end
        rv = res[7:0];
    endtask : cmd

    task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_reg

    task automatic check_pin(input string what, input logic exp, input logic got);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check_pin

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        check_pin("moduleEnable", 1'b0, moduleEnable);
        check_pin("engineClkRun", 1'b1, engineClkRun);
        check_pin("pinChangeDetectEnable", 1'b1, pinChangeDetectEnable);
        check_pin("pullupDp", 1'b0, pullupDp | pullupDm);
        cmd(1'b1, usbsc_pkg::REG_CTRL, 8'h00);
        check_reg("ctrl", 8'h00, rv);
        check_pin("cmdBusy", 1'b0, cmdBusy);
        check_pin("hresp", 1'b0, hresp);
        cmd(1'b1, usbsc_pkg::REG_STAT, 8'h00);
        check_reg("stat", 8'h00, rv);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000, res);
        check_reg("unmapped", 8'h00, res[7:0]);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_config;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {i[0], 3'h7, 1'b1, i[1], i[1:0]};
            cmd(1'b0, usbsc_pkg::REG_CFG, v);
            cmd(1'b1, usbsc_pkg::REG_CFG, 8'h00);
            check_reg("cfg", v & 8'h97, rv);
            check_reg("pingpongMode", {6'h00, i[1:0]}, {6'h00, pingpongMode});
            check_pin("eyeTestEnable", i[0], eyeTestEnable);
            check_pin("speedSelect", i[1], speedSelect);
            check_pin("pullupDp", i[1], pullupDp);
            check_pin("pullupDm", !i[1], pullupDm);
        end
        cmd(1'b0, usbsc_pkg::REG_CFG, 8'h04);
        check_pin("pullupDp", 1'b0, pullupDp);
        $display("Test config done");
    endtask : t_config

    task automatic t_enable;
        cmd(1'b0, usbsc_pkg::REG_CFG, 8'h14);
        moduleClkMhz <= usbsc_pkg::LS_CLK_MHZ;
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'h08);
        check_pin("refused", 1'b1, res[9]);
        check_pin("cmdRefused", 1'b1, cmdRefused);
        check_pin("moduleEnable", 1'b0, moduleEnable);
        moduleClkMhz <= usbsc_pkg::FS_CLK_MHZ;
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'h08);
        check_pin("moduleEnable", 1'b1, moduleEnable);
        check_pin("cmdRefused", 1'b0, cmdRefused);
        check_pin("pinChangeDetectEnable", 1'b0, pinChangeDetectEnable);
        cmd(1'b0, usbsc_pkg::REG_CFG, 8'h10);
        check_pin("refused", 1'b1, res[9]);
        check_pin("speedSelect", 1'b1, speedSelect);
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'hDF);
        cmd(1'b1, usbsc_pkg::REG_CTRL, 8'h00);
        check_reg("ctrl", 8'h4E, rv);
        check_pin("resumeDrive", 1'b1, resumeDrive);
        check_pin("engineClkRun", 1'b0, engineClkRun);
        check_pin("pingpongPointerClear", 1'b1, pingpongPointerClear);
        check_pin("packetLockout", 1'b0, packetLockout);
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'h08);
        check_pin("resumeDrive", 1'b0, resumeDrive);
        check_pin("engineClkRun", 1'b1, engineClkRun);
        check_pin("pingpongPointerClear", 1'b0, pingpongPointerClear);
        $display("Test enable done");
    endtask : t_enable

    task automatic t_lockout;
        setupSeen <= 1'b1;
        @(posedge sys_clk);
        setupSeen <= 1'b0;
        busDp <= 1'b0;
        busDm <= 1'b0;
        @(posedge sys_clk);
        check_pin("packetLockout", 1'b1, packetLockout);
        cmd(1'b1, usbsc_pkg::REG_CTRL, 8'h00);
        check_reg("ctrl", 8'h38, rv);
        busDp <= 1'b1;
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'h08);
        check_pin("packetLockout", 1'b0, packetLockout);
        cmd(1'b1, usbsc_pkg::REG_CTRL, 8'h00);
        check_reg("ctrl", 8'h08, rv);
        $display("Test lockout done");
    endtask : t_lockout

    task automatic t_queue;
        logic [5:0] tbl [5] = '{6'h3F, 6'h00, 6'h16, 6'h29, 6'h0F};
        for (int k = 0; k < 5; k++) begin
            {xferEndp, xferDir, xferBank} <= tbl[k];
            xferDone <= 1'b1;
            @(posedge sys_clk);
        end
        xferDone <= 1'b0;
        @(posedge sys_clk);
        check_pin("statusQueueFull", 1'b1, statusQueueFull);
        for (int k = 0; k < 4; k++) begin
            check_pin("transactionDone", 1'b1, transactionDone);
            cmd(1'b1, usbsc_pkg::REG_STAT, 8'h00);
            check_reg("stat", {1'b0, tbl[k], 1'b0}, rv);
            cmd(1'b0, usbsc_pkg::REG_DONE, 8'h01);
        end
        check_pin("transactionDone", 1'b0, transactionDone);
        cmd(1'b0, usbsc_pkg::REG_CTRL, 8'h00);
        check_pin("pinChangeDetectEnable", 1'b1, pinChangeDetectEnable);
        $display("Test queue done");
    endtask : t_queue

    task automatic test_done;
        $display("Checked %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // Sequence and watchdog
    // ************************************************************
    initial begin
        rstn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        moduleClkMhz = 8'h00;
        {busDp, busDm, setupSeen, xferDone, xferDir, xferBank} = 6'h20;
        xferEndp = 4'h0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_config();
        t_enable();
        t_lockout();
        t_queue();
        test_done();
    end

    // Whole run is about two hundred cycles; this is over a hundred times that
    initial begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
endmodule : testbench

// ### tb/usbsc_monitor.sv
// Checker for the register port between the controller and the front end.
// Assumes both ends run on sys_clk and the bench instantiates it beside the port.
`timescale 1ns/1ns
module usbsc_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic regReq,
    input wire logic regWe,
    input wire logic [1:0] regIdx,
    input wire logic [7:0] regWdata,
    input wire logic regAck,
    input wire logic [7:0] regRdata
);
    // ************************************************************
    // Port timing
    // ************************************************************
    default clocking monClk @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    ack_follow_a: assert property (regReq |=> regAck)
        else $error("Register request not acknowledged one cycle later");
    ack_cause_a: assert property (regAck |-> $past(regReq))
        else $error("Register acknowledge without a request");
    req_gap_a: assert property (regReq |=> !regReq [*2])
        else $error("Register requests closer than three cycles");
    // Read data must stand between acknowledges, the controller may sample late
    rdata_hold_a: assert property (!regAck |-> $stable(regRdata))
        else $error("Register read data moved without an acknowledge");

    // ************************************************************
    // Read-back layout
    // ************************************************************
    cfg_reserved_a: assert property (
        regAck && regIdx == usbsc_pkg::REG_CFG |-> (regRdata & 8'h68) == 8'h00)
        else $error("Configuration reserved bits read nonzero");
    ctrl_unused_a: assert property (
        regAck && regIdx == usbsc_pkg::REG_CTRL |-> (regRdata & 8'h81) == 8'h00)
        else $error("Control unused bits read nonzero");
    stat_unused_a: assert property (
        regAck && regIdx == usbsc_pkg::REG_STAT |-> (regRdata & 8'h81) == 8'h00)
        else $error("Status unused bits read nonzero");
    done_unused_a: assert property (
        regAck && regIdx == usbsc_pkg::REG_DONE |-> regRdata[7:1] == 7'h00)
        else $error("Done register upper bits read nonzero");
    cfg_clean_a: assert property (
        regReq && regWe && regIdx == usbsc_pkg::REG_CFG |-> (regWdata & 8'h68) == 8'h00)
        else $error("Configuration write carries reserved bits");
endmodule : usbsc_monitor
